// ---- src/rail_pkg.sv ----
package rail_pkg;
   // clock and timing
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned SHORT_DLY_NS = 10000;
   localparam int unsigned SHORT_DLY_CYC = SHORT_DLY_NS * CLK_MHZ / 1000;
   localparam int unsigned PD_DLY_US = 100;
   localparam int unsigned PD_DLY_CYC = PD_DLY_US * CLK_MHZ;
   localparam int unsigned CNT_W = 16;
   // short threshold, percent of target magnitude
   localparam logic [6:0] SHORT_PCT = 7'h28;
   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h00;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFS_LIVE = 8'h08;
   localparam logic [7:0] OFS_GLBL_CFG = 8'h0C;
   localparam logic [7:0] OFS_DCDC_CFG = 8'h10;
   localparam logic [7:0] OFS_VCODE_UP = 8'h14;
   localparam logic [7:0] OFS_VCODE_LO = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1C;
   // bit positions
   localparam int unsigned BIT_NEG = 0;
   localparam int unsigned BIT_POS = 1;
   localparam int unsigned BIT_RANGE = 0;
   localparam int unsigned BIT_PK_LO = 1;
   // reset values and the DCM-only peak limit code
   localparam logic [1:0] MASK_RST = 2'h3;
   localparam logic [8:0] VCODE_RST = 9'h000;
   localparam logic [1:0] PEAK_RST = 2'h0;
   localparam logic [1:0] PEAK_DCM = 2'h3;
   typedef enum logic [1:0] {RAIL_OFF, RAIL_ON, RAIL_SHORT_WAIT,
                             RAIL_TRIPPED} rail_state_t;
endpackage

// ---- src/rail_guard.sv ----
`timescale 1ns/1ns
// one rail: short delay timer, trip latch, power-down delay
module rail_guard
   import rail_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic force_on_i,
   input wire logic short_i,
   output logic on_o,
   output logic powered_o,
   output logic trip_o,
   output rail_state_t state_o
);
   rail_state_t state_q, state_d;
   logic [CNT_W-1:0] sc_q;
   logic [CNT_W-1:0] pd_q;
   logic pd_busy_q;
   logic sc_done, pd_done, want_on;

   assign sc_done = (sc_q == CNT_W'(SHORT_DLY_CYC - 1));
   assign pd_done = (pd_q == CNT_W'(PD_DLY_CYC - 1));
   // force-on skips the power-down wait after a trip
   assign want_on = (en_i && !pd_busy_q) || force_on_i;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RAIL_OFF: if (want_on) state_d = RAIL_ON;
         RAIL_ON: begin
            if (short_i) state_d = RAIL_SHORT_WAIT;
            else if (!en_i && !force_on_i && pd_done) state_d = RAIL_OFF;
         end
         RAIL_SHORT_WAIT: begin
            if (!short_i) state_d = RAIL_ON;
            else if (sc_done) state_d = RAIL_TRIPPED;
         end
         RAIL_TRIPPED: begin
            if (force_on_i) state_d = RAIL_ON;
            else if (!en_i) state_d = RAIL_OFF;
         end
      endcase
   end

   // short delay counter runs only while the short persists
   always_ff @(posedge clk_i) begin
      if (rst_i || state_q != RAIL_SHORT_WAIT) sc_q <= '0;
      else sc_q <= sc_q + 1'b1;
   end

   // power-down delay: counts while enable is low; also gates re-enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pd_q <= '0;
         pd_busy_q <= 1'b0;
      end else if (en_i || force_on_i || pd_done) begin
         pd_q <= '0;
         pd_busy_q <= 1'b0;
      end else if (state_q == RAIL_ON || state_q == RAIL_TRIPPED
                   || pd_busy_q) begin
         pd_q <= pd_q + 1'b1;
         pd_busy_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= RAIL_OFF;
         on_o <= 1'b0;
         powered_o <= 1'b0;
         trip_o <= 1'b0;
      end else begin
         state_q <= state_d;
         on_o <= (state_d == RAIL_ON) || (state_d == RAIL_SHORT_WAIT);
         // powered flag cleared by force-on, set after normal power-up
         powered_o <= (state_d == RAIL_ON || state_d == RAIL_SHORT_WAIT)
                      && !force_on_i;
         trip_o <= (state_q == RAIL_SHORT_WAIT) && (state_d == RAIL_TRIPPED);
      end
   end

   assign state_o = state_q;
endmodule

// ---- src/rail_protect.sv ----
`timescale 1ns/1ns
module rail_protect
   import rail_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins and analog comparators
   input wire logic en_i,
   input wire logic [8:0] neg_mag_i,
   input wire logic pos_below_in_i,
   // regulator controls and interrupt
   output logic neg_rail_on_o,
   output logic pos_rail_on_o,
   output logic neg_rail_range_sel_o,
   output logic [8:0] neg_rail_vcode_o,
   output logic pos_rail_dcm_only_o,
   output logic irq_o
);
   // pin and comparator synchronisers
   logic en_s1_q, en_s2_q;
   logic [8:0] nm_s1_q, nm_s2_q;
   logic pb_s1_q, pb_s2_q;
   always_ff @(posedge clk_i) begin
      en_s1_q <= en_i;
      en_s2_q <= en_s1_q;
      nm_s1_q <= neg_mag_i;
      nm_s2_q <= nm_s1_q;
      pb_s1_q <= pos_below_in_i;
      pb_s2_q <= pb_s1_q;
   end
   logic en_sync;
   logic [8:0] neg_mag;
   assign en_sync = en_s2_q;
   assign neg_mag = nm_s2_q;

   // registers
   logic [1:0] irq_flag_q, irq_mask_q;
   logic neg_rail_force_on_q, pos_rail_force_on_q;
   logic neg_rail_range_sel_q;
   logic [1:0] pos_rail_peak_limit_sel_q;
   logic neg_rail_vcode_upper_q;
   logic [7:0] neg_rail_vcode_lower_q;
   logic [8:0] vcode_q;

   // short detection: magnitude*100 <= code*40 compares without division;
   // the code is treated as proportional to the target magnitude, which the
   // comparator front end scales the same way
   logic [15:0] mag_scaled, tgt_scaled;
   logic neg_short, pos_short;
   assign mag_scaled = 16'(neg_mag) * 16'h0064;
   assign tgt_scaled = 16'(vcode_q) * 16'(SHORT_PCT);
   assign neg_short = neg_rail_on_o && (mag_scaled <= tgt_scaled);
   assign pos_short = pos_rail_on_o && pb_s2_q;

   logic neg_on, pos_on, neg_trip, pos_trip;
   logic neg_pwr, pos_pwr;
   rail_state_t neg_st, pos_st;

   rail_guard u_neg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(en_sync),
      .force_on_i(neg_rail_force_on_q),
      .short_i(neg_short),
      .on_o(neg_on),
      .powered_o(neg_pwr),
      .trip_o(neg_trip),
      .state_o(neg_st)
   );

   rail_guard u_pos (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(en_sync),
      .force_on_i(pos_rail_force_on_q),
      .short_i(pos_short),
      .on_o(pos_on),
      .powered_o(pos_pwr),
      .trip_o(pos_trip),
      .state_o(pos_st)
   );

   // live flags are held set while the rail sits tripped and follow the short otherwise
   logic [1:0] live;
   assign live[BIT_NEG] = (neg_st == RAIL_TRIPPED) || neg_short;
   assign live[BIT_POS] = (pos_st == RAIL_TRIPPED) || pos_short;

   // bus decode
   logic req, wr, rd;
   logic hit_flag, hit_mask, hit_glbl, hit_dcdc, hit_up, hit_lo;
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i && sel_i[0];
   assign rd = req && !we_i;
   assign hit_flag = (adr_i == OFS_IRQ_FLAG);
   assign hit_mask = (adr_i == OFS_IRQ_MASK);
   assign hit_glbl = (adr_i == OFS_GLBL_CFG);
   assign hit_dcdc = (adr_i == OFS_DCDC_CFG);
   assign hit_up = (adr_i == OFS_VCODE_UP);
   assign hit_lo = (adr_i == OFS_VCODE_LO);

   logic [31:0] rd_mux;
   always_comb begin
      unique case (adr_i)
         OFS_IRQ_FLAG: rd_mux = {30'h0, irq_flag_q};
         OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
         OFS_LIVE: rd_mux = {30'h0, live};
         OFS_GLBL_CFG: rd_mux = {30'h0, pos_rail_force_on_q,
                                 neg_rail_force_on_q};
         OFS_DCDC_CFG: rd_mux = {29'h0, pos_rail_peak_limit_sel_q,
                                 neg_rail_range_sel_q};
         OFS_VCODE_UP: rd_mux = {31'h0, neg_rail_vcode_upper_q};
         OFS_VCODE_LO: rd_mux = {24'h0, neg_rail_vcode_lower_q};
         OFS_STATE: rd_mux = {20'h0, 2'(pos_st), 2'(neg_st),
                              6'h0, pos_pwr, neg_pwr};
         default: rd_mux = 32'h0000_0000; // unmapped reads as zero
      endcase
   end

   // every access acks in the cycle after it is seen, unmapped included
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (rd) dat_o <= rd_mux;
      end
   end

   // sticky flags: a trip in the clear cycle wins over the clear
   logic [1:0] trips, clr;
   assign trips = {pos_trip, neg_trip};
   assign clr = (wr && hit_flag) ? dat_i[1:0] : 2'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) irq_flag_q <= 2'h0;
      else irq_flag_q <= (irq_flag_q & ~clr) | trips;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) irq_mask_q <= MASK_RST;
      else if (wr && hit_mask) irq_mask_q <= dat_i[1:0];
   end

   // configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neg_rail_force_on_q <= 1'b0;
         pos_rail_force_on_q <= 1'b0;
         neg_rail_range_sel_q <= 1'b0;
         pos_rail_peak_limit_sel_q <= PEAK_RST;
      end else begin
         if (wr && hit_glbl) begin
            neg_rail_force_on_q <= dat_i[BIT_NEG];
            pos_rail_force_on_q <= dat_i[BIT_POS];
         end
         // host is expected to disable the converter first; not enforced
         if (wr && hit_dcdc) begin
            neg_rail_range_sel_q <= dat_i[BIT_RANGE];
            pos_rail_peak_limit_sel_q <= dat_i[BIT_PK_LO +: 2];
         end
      end
   end

   // upper bit is staged; the nine bits commit together on the lower write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neg_rail_vcode_upper_q <= VCODE_RST[8];
         neg_rail_vcode_lower_q <= VCODE_RST[7:0];
         vcode_q <= VCODE_RST;
      end else begin
         if (wr && hit_up) neg_rail_vcode_upper_q <= dat_i[0];
         if (wr && hit_lo) begin
            neg_rail_vcode_lower_q <= dat_i[7:0];
            vcode_q <= {neg_rail_vcode_upper_q, dat_i[7:0]};
         end
      end
   end

   // registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         neg_rail_on_o <= 1'b0;
         pos_rail_on_o <= 1'b0;
         neg_rail_range_sel_o <= 1'b0;
         neg_rail_vcode_o <= VCODE_RST;
         pos_rail_dcm_only_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         neg_rail_on_o <= neg_on;
         pos_rail_on_o <= pos_on;
         neg_rail_range_sel_o <= neg_rail_range_sel_q;
         neg_rail_vcode_o <= vcode_q;
         pos_rail_dcm_only_o <= (pos_rail_peak_limit_sel_q == PEAK_DCM);
         irq_o <= |(irq_flag_q & ~irq_mask_q);
      end
   end
endmodule

// ---- testbench/rail_analog_model.sv ----
`timescale 1ns/1ns
// comparators behind both rails; a commanded short collapses one output
module rail_analog_model
   import rail_pkg::*;
(
   input wire logic neg_on_i,
   input wire logic pos_on_i,
   input wire logic [8:0] vcode_i,
   input wire logic neg_short_i,
   input wire logic pos_short_i,
   output logic [8:0] neg_mag_o,
   output logic pos_below_in_o
);
   // short lands exactly on the 40 percent point to probe the boundary
   assign neg_mag_o = !neg_on_i ? 9'h000 : neg_short_i ?
      9'(32'(vcode_i) * 40 / 100) : vcode_i;
   // an idle boost only passes input through a diode, so reads below it
   assign pos_below_in_o = !pos_on_i || pos_short_i;
endmodule

// ---- testbench/rail_protect_monitor.sv ----
`timescale 1ns/1ns
// port-level checker; short lengths are timed from the raw comparators
module rail_protect_monitor
   import rail_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic en_i,
   input wire logic [8:0] neg_mag_i,
   input wire logic pos_below_in_i,
   input wire logic neg_rail_on_o,
   input wire logic pos_rail_on_o,
   input wire logic neg_rail_range_sel_o,
   input wire logic [8:0] neg_rail_vcode_o,
   input wire logic pos_rail_dcm_only_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // decoded write strobe and per-rail short conditions
   wire wr_w = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   wire neg_sh_w = neg_rail_on_o &&
      (32'(neg_mag_i) * 100 <= 32'(neg_rail_vcode_o) * 40);
   wire pos_sh_w = pos_rail_on_o && pos_below_in_i;
   logic [15:0] neg_cnt_q;
   logic [15:0] pos_cnt_q;
   // saturating run lengths, so a long fault cannot wrap to a small count
   always_ff @(posedge clk_i) begin
      neg_cnt_q <= (rst_i || !neg_sh_w) ? 16'h0000
         : neg_cnt_q + 16'(~&neg_cnt_q);
      pos_cnt_q <= (rst_i || !pos_sh_w) ? 16'h0000
         : pos_cnt_q + 16'(~&pos_cnt_q);
   end
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   a_range_write: assert property (wr_w && adr_i == OFS_DCDC_CFG
      |=> ##1 neg_rail_range_sel_o == $past(dat_i[0], 2))
      else $error("range bit");
   a_dcm_write: assert property (wr_w && adr_i == OFS_DCDC_CFG
      |=> ##1 pos_rail_dcm_only_o == ($past(dat_i[2:1], 2) == PEAK_DCM))
      else $error("dcm output");
   a_vcode_commit: assert property (wr_w && adr_i == OFS_VCODE_LO
      |=> ##1 neg_rail_vcode_o[7:0] == $past(dat_i[7:0], 2))
      else $error("vcode not committed");
   a_vcode_atomic: assert property ($changed(neg_rail_vcode_o) |->
      $past(wr_w && adr_i == OFS_VCODE_LO, 2)) else $error("vcode moved");
   a_neg_trip_time: assert property ($fell(neg_rail_on_o) && en_i
      && $past(en_i, 4) |-> neg_cnt_q inside
      {[SHORT_DLY_CYC:SHORT_DLY_CYC + 12]}) else $error("neg trip time");
   a_pos_trip_time: assert property ($fell(pos_rail_on_o) && en_i
      && $past(en_i, 4) |-> pos_cnt_q inside
      {[SHORT_DLY_CYC:SHORT_DLY_CYC + 12]}) else $error("pos trip time");
   a_irq_masked: assert property (wr_w && adr_i == OFS_IRQ_MASK
      && dat_i[1:0] == 2'h3 |-> ##[2:3] !irq_o) else $error("irq masked");
   c_neg_trip: cover property ($fell(neg_rail_on_o) && en_i);
   c_pos_trip: cover property ($fell(pos_rail_on_o) && en_i);
   c_vcode: cover property ($changed(neg_rail_vcode_o));
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   import rail_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, en_i = 1'b0, neg_sh = 1'b0, pos_sh = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, neg_rail_on_o, pos_rail_on_o, neg_rail_range_sel_o;
   logic pos_rail_dcm_only_o, irq_o, pos_below_in_i;
   logic [8:0] neg_rail_vcode_o, neg_mag_i;
   int errors = 0, n_compared = 0;
   always #2 clk_i = ~clk_i;
   rail_protect dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .en_i(en_i), .neg_mag_i(neg_mag_i),
      .pos_below_in_i(pos_below_in_i), .neg_rail_on_o(neg_rail_on_o),
      .pos_rail_on_o(pos_rail_on_o),
      .neg_rail_range_sel_o(neg_rail_range_sel_o),
      .neg_rail_vcode_o(neg_rail_vcode_o),
      .pos_rail_dcm_only_o(pos_rail_dcm_only_o), .irq_o(irq_o)
   );
   rail_analog_model ana (.neg_on_i(neg_rail_on_o), .pos_on_i(pos_rail_on_o),
      .vcode_i(neg_rail_vcode_o), .neg_short_i(neg_sh),
      .pos_short_i(pos_sh), .neg_mag_o(neg_mag_i),
      .pos_below_in_o(pos_below_in_i));
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, d};
      for (i = 0; i < 20 && ack_o !== 1'b1; i++) begin
         @(posedge clk_i);
      end
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'h0;
      check("ack", 32'h1, 32'(i < 20));
      if (i == 20) end_sim();
   endtask
   // bounded poll of a rail enable
   task automatic wait_rail(input logic p, input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim && (p ? pos_rail_on_o : neg_rail_on_o) !== lvl;
           i++) begin
         @(posedge clk_i);
      end
      check(p ? "pos rail" : "neg rail", 32'(lvl),
            32'(p ? pos_rail_on_o : neg_rail_on_o));
      if (i == lim) end_sim();
   endtask
   task automatic t_regs();
      bus(1'b0, OFS_IRQ_MASK, 32'h0);
      check("mask", 32'(MASK_RST), rd);
      bus(1'b0, 8'h40, 32'h0);
      check("unmapped", 32'h0, rd);
      bus(1'b1, OFS_VCODE_UP, 32'h1);
      repeat (3) @(posedge clk_i);
      check("vcode held", 32'h0, 32'(neg_rail_vcode_o));
      bus(1'b1, OFS_VCODE_LO, 32'h2C);
      repeat (2) @(posedge clk_i);
      check("vcode", 32'h12C, 32'(neg_rail_vcode_o));
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, OFS_DCDC_CFG, 32'(k * 2 + k % 2));
         // outputs are registered once more after the write lands
         @(posedge clk_i);
         check("dcm", 32'(k == 3), 32'(pos_rail_dcm_only_o));
         check("range", 32'(k % 2), 32'(neg_rail_range_sel_o));
      end
      $display("register test done");
   endtask
   task automatic t_short(input logic p);
      if (p) neg_sh <= 1'b0;
      if (p) pos_sh <= 1'b1;
      else neg_sh <= 1'b1;
      repeat (SHORT_DLY_CYC - 10) @(posedge clk_i);
      wait_rail(p, 1'b1, 1);
      wait_rail(p, 1'b0, 40);
      bus(1'b0, OFS_IRQ_FLAG, 32'h0);
      check("flag", p ? 32'h2 : 32'h1, rd);
      bus(1'b0, OFS_LIVE, 32'h0);
      check("live", p ? 32'h2 : 32'h1, rd);
      check("irq", 32'(!p), 32'(irq_o));
      $display("short test done");
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      bus(1'b1, OFS_IRQ_MASK, 32'h2);
      en_i <= 1'b1;
      wait_rail(1'b0, 1'b1, 100);
      t_short(1'b0);
      // remove the fault so the later restart comes up clean
      neg_sh <= 1'b0;
      bus(1'b1, OFS_IRQ_MASK, 32'h3);
      @(posedge clk_i);
      check("irq masked", 32'h0, 32'(irq_o));
      bus(1'b1, OFS_IRQ_MASK, 32'h2);
      bus(1'b1, OFS_IRQ_FLAG, 32'h1);
      bus(1'b0, OFS_IRQ_FLAG, 32'h0);
      check("flag clear", 32'h0, rd);
      check("irq clear", 32'h0, 32'(irq_o));
      en_i <= 1'b0;
      repeat (PD_DLY_CYC - 20) @(posedge clk_i);
      wait_rail(1'b1, 1'b1, 1);
      wait_rail(1'b1, 1'b0, 60);
      en_i <= 1'b1;
      wait_rail(1'b0, 1'b1, 100);
      bus(1'b1, OFS_GLBL_CFG, 32'h2);
      t_short(1'b1);
      pos_sh <= 1'b0;
      // forced rail is back on with enable still high, no power-down wait
      wait_rail(1'b1, 1'b1, 10);
      en_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      en_i <= 1'b1;
      wait_rail(1'b1, 1'b1, 100);
      $display("restart test done");
      end_sim();
   end
endmodule
bind rail_protect rail_protect_monitor mon (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .en_i(en_i), .neg_mag_i(neg_mag_i),
   .pos_below_in_i(pos_below_in_i), .neg_rail_on_o(neg_rail_on_o),
   .pos_rail_on_o(pos_rail_on_o),
   .neg_rail_range_sel_o(neg_rail_range_sel_o),
   .neg_rail_vcode_o(neg_rail_vcode_o),
   .pos_rail_dcm_only_o(pos_rail_dcm_only_o), .irq_o(irq_o)
);
